// >>> core/mdw_cfg.svh
// offsets, fields, reset values and timing counts of the watchdog
`ifndef MDW_CFG_SVH
`define MDW_CFG_SVH

`define MDW_ADDR_W 12
`define MDW_DATA_W 8

`define MDW_SETUP_ADDR 12'h034
`define MDW_CODE_ADDR 12'h035
`define MDW_STATUS_ADDR 12'h03C

`define MDW_RUN_BIT 3
`define MDW_PERIOD_HI 2
`define MDW_PERIOD_LO 1
`define MDW_ACTION_BIT 0

`define MDW_RUN_INIT 1'h1
`define MDW_PERIOD_INIT 2'h0
`define MDW_ACTION_INIT 1'h1

`define MDW_CLEAR_CODE 8'h4E
`define MDW_DISABLE_CODE 8'hB1

`define MDW_TAP_LOW_DEF 16
`define MDW_RST_HOLD_CYC 5'h18

`endif

// >>> core/mdw_pkg.sv
// types shared by the watchdog design files
package mdw_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mdw_bus_req_t;

  typedef struct packed {
    logic running;
    logic enable_bit;
    logic action;
    logic [1:0] period;
    logic [1:0] bin_count;
  } mdw_state_t;

  typedef enum logic [1:0] {
    MDW_RUN = 2'b00,
    MDW_HOLD_RST = 2'b01,
    MDW_IDLE = 2'b10
  } mdw_fsm_t;

endpackage : mdw_pkg

// >>> core/mdw_divider.sv
// prescaling divider with four selectable detection taps
`timescale 1ns/1ps
`default_nettype none
`include "mdw_cfg.svh"
module mdw_divider #(
  parameter int TAP_LOW = `MDW_TAP_LOW_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic advance,
  input wire logic [1:0] period_sel,
  output logic tick
);
  localparam int DW = TAP_LOW + 7;

  logic [DW-1:0] div_reg;
  logic [3:0] fall;

  // counts only on advance, not touched by the clear code
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_reg <= '0;
    end else if (advance) begin
      div_reg <= div_reg + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // tap k falls when all bits up to it wrap; select 00 is the slowest
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_tap
      localparam int B = TAP_LOW + 6 - 2 * k;
      assign fall[k] = advance && (&div_reg[B:0]);
    end
  endgenerate

  assign tick = fall[period_sel];
endmodule : mdw_divider
`default_nettype wire

// >>> core/mdw_watchdog.sv
// malfunction detect watchdog with register port and reset pin drive
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mdw_cfg.svh"
module mdw_watchdog
  import mdw_pkg::*;
#(
  parameter int TAP_LOW = `MDW_TAP_LOW_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic low_power_hold,
  output logic watchdog_overflow_irq,
  output logic watchdog_reset_req,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n
);

  mdw_bus_req_t bus;
  mdw_state_t state;
  mdw_fsm_t fsm_reg;
  mdw_fsm_t fsm_next;

  logic run_reg;
  logic enable_bit_reg;
  logic action_reg;
  logic [1:0] period_reg;
  logic [1:0] bin_reg;
  logic [4:0] hold_reg;
  logic irq_reg;
  logic [7:0] rdata_reg;
  logic [2:0] pin_sync_reg;
  logic pin_low_reg;

  logic wr_setup;
  logic wr_code;
  logic clear_hit;
  logic disable_hit;
  logic advance;
  logic tick;
  logic overflow;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  assign wr_setup = bus.wr && (bus.addr == `MDW_SETUP_ADDR);
  assign wr_code = bus.wr && (bus.addr == `MDW_CODE_ADDR);
  assign clear_hit = wr_code && (bus.wdata == `MDW_CLEAR_CODE);
  assign disable_hit = wr_code && (bus.wdata == `MDW_DISABLE_CODE)
                       && !enable_bit_reg;

  // counting only while enabled and not in a low power mode
  assign advance = run_reg && !low_power_hold && (fsm_reg == MDW_RUN);

  mdw_divider #(
    .TAP_LOW(TAP_LOW)
  ) u_div (
    .mclk(mclk),
    .srst(srst),
    .advance(advance),
    .period_sel(period_reg),
    .tick(tick)
  );

  assign overflow = tick && (bin_reg == 2'h3);

  // enable bit and run state
  always_ff @(posedge mclk) begin
    if (srst) begin
      enable_bit_reg <= `MDW_RUN_INIT;
      run_reg <= `MDW_RUN_INIT;
    end else begin
      if (wr_setup) begin
        enable_bit_reg <= bus.wdata[`MDW_RUN_BIT];
      end
      if (wr_setup && bus.wdata[`MDW_RUN_BIT]) begin
        run_reg <= 1'b1;
      end else if (disable_hit) begin
        run_reg <= 1'b0;
      end
    end
  end

  // detection period select
  always_ff @(posedge mclk) begin
    if (srst) begin
      period_reg <= `MDW_PERIOD_INIT;
    end else if (wr_setup) begin
      period_reg <= bus.wdata[`MDW_PERIOD_HI:`MDW_PERIOD_LO];
    end
  end

  // overflow action: once cleared to interrupt it stays there
  always_ff @(posedge mclk) begin
    if (srst) begin
      action_reg <= `MDW_ACTION_INIT;
    end else if (wr_setup) begin
      action_reg <= action_reg & bus.wdata[`MDW_ACTION_BIT];
    end
  end

  // two-stage binary counter, cleared by code or while disabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      bin_reg <= 2'h0;
    end else if (!run_reg || clear_hit || fsm_reg != MDW_RUN) begin
      bin_reg <= 2'h0;
    end else if (tick) begin
      bin_reg <= bin_reg + 2'h1;
    end
  end

  // interrupt pulse, independent of any interrupt permit
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= overflow && !action_reg;
    end
  end

  assign watchdog_overflow_irq = irq_reg;

  // reset request sequencing
  always_comb begin
    fsm_next = fsm_reg;
    unique case (fsm_reg)
      MDW_RUN: begin
        if (overflow && action_reg) begin
          fsm_next = MDW_HOLD_RST;
        end
      end
      MDW_HOLD_RST: begin
        if (hold_reg == `MDW_RST_HOLD_CYC) begin
          fsm_next = MDW_IDLE;
        end
      end
      MDW_IDLE: begin
        if (!pin_low_reg) begin
          fsm_next = MDW_RUN;
        end
      end
      default: begin
        fsm_next = MDW_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fsm_reg <= MDW_RUN;
    end else begin
      fsm_reg <= fsm_next;
    end
  end

  // length of the low pulse on the reset pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_reg <= 5'h00;
    end else if (fsm_reg == MDW_HOLD_RST) begin
      hold_reg <= hold_reg + 5'h01;
    end else begin
      hold_reg <= 5'h00;
    end
  end

  // reset pin read back; waits until the pin has risen again
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_sync_reg <= 3'h7;
      pin_low_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_in};
      if (pin_sync_reg[2] == pin_sync_reg[1]) begin
        pin_low_reg <= !pin_sync_reg[2];
      end
    end
  end

  // open drain drive: enable low pulls the pin low
  assign watchdog_reset_req = (fsm_reg == MDW_HOLD_RST);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = (fsm_reg != MDW_HOLD_RST);

  // status read; setup and code registers read as zero
  assign state = '{running: run_reg, enable_bit: enable_bit_reg,
                   action: action_reg, period: period_reg,
                   bin_count: bin_reg};

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd && bus.addr == `MDW_STATUS_ADDR) begin
      rdata_reg <= {1'b0, state};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : mdw_watchdog
`default_nettype wire

// >>> verification/mdw_chk.sv
// port assertions for the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "mdw_cfg.svh"
module mdw_chk #(
  parameter int TAP_LOW = `MDW_TAP_LOW_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic low_power_hold,
  input wire logic watchdog_overflow_irq,
  input wire logic watchdog_reset_req,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_oe_req; reset_pin_oe_n == !watchdog_reset_req; endproperty
  a_oe_req: assert property (p_oe_req)
    else $error("pin and req differ");
  property p_pin_out; reset_pin_out == 1'b0; endproperty
  a_pin_out: assert property (p_pin_out)
    else $error("pin data high");
  property p_hold_len;
    $fell(reset_pin_oe_n) |-> (!reset_pin_oe_n)[*8] ##17 !reset_pin_oe_n
      ##1 reset_pin_oe_n;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("bad low width");
  property p_release;
    $rose(reset_pin_oe_n) |-> reset_pin_oe_n[*8];
  endproperty
  a_release: assert property (p_release)
    else $error("pin re-driven");
  property p_irq_pulse;
    watchdog_overflow_irq |=> !watchdog_overflow_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq too long");
  property p_irq_only; watchdog_overflow_irq |-> reset_pin_oe_n; endproperty
  a_irq_only: assert property (p_irq_only)
    else $error("irq with reset");
  property p_freeze;
    low_power_hold |=> !watchdog_overflow_irq && !$fell(reset_pin_oe_n);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("overflow in hold");
  property p_clear_gap;
    reg_wr && reg_addr == `MDW_CODE_ADDR && reg_wdata == `MDW_CLEAR_CODE
      |-> ##2 (!watchdog_overflow_irq)[*8];
  endproperty
  a_clear_gap: assert property (p_clear_gap)
    else $error("irq after clear");
  property p_after_rst;
    $fell(srst) |-> reset_pin_oe_n && !watchdog_overflow_irq;
  endproperty
  a_after_rst: assert property (p_after_rst)
    else $error("bad reset state");
endmodule : mdw_chk
bind mdw_watchdog mdw_chk #(.TAP_LOW(TAP_LOW)) mdw_chk_inst (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .low_power_hold(low_power_hold),
  .watchdog_overflow_irq(watchdog_overflow_irq),
  .watchdog_reset_req(watchdog_reset_req), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n)
);
`default_nettype wire

// >>> verification/mdw_watchdog_bench.sv
// self-checking bench for the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "mdw_cfg.svh"
module mdw_watchdog_bench;
  logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, lph = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic irq, rreq, pin_in, pin_out, pin_oe_n;
  int errors = 0, n_tests = 0, cnt;
  always #20 mclk = ~mclk;
  // pull-up on the reset pin
  assign pin_in = pin_oe_n ? 1'b1 : pin_out;
  mdw_watchdog #(.TAP_LOW(2)) mdw_watchdog_inst (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_power_hold(lph), .watchdog_overflow_irq(irq),
    .watchdog_reset_req(rreq), .reset_pin_in(pin_in),
    .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n)
  );
  task test_done;
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdc(input string nm, input logic [11:0] a, input logic [7:0] e, m);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata & m, e);
  endtask : rdc
  // counts edges until irq (s=0) or pin low (s=1), at most n
  task wsig(input bit s, input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if ((s ? !pin_oe_n : irq) === 1'b1) break;
      cnt++;
    end
  endtask : wsig
  task rst;
    @(posedge mclk) srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
  endtask : rst
  initial begin
    rst;
    rdc("status", `MDW_STATUS_ADDR, 8'h70, 8'hFF);
    @(posedge mclk);
    #1 chk("rd gone", reg_rdata, 8'h00);
    rdc("setup", `MDW_SETUP_ADDR, 8'h00, 8'hFF);
    rdc("unmapped", 12'h100, 8'h00, 8'hFF);
    wr(`MDW_SETUP_ADDR, 8'h0E);
    wr(`MDW_SETUP_ADDR, 8'h0F);
    rdc("action", `MDW_STATUS_ADDR, 8'h6C, 8'hFC);
    wsig(0, 40);
    chk("irq", cnt < 40, 1);
    chk("no pin", pin_oe_n, 1);
    repeat (12) @(posedge mclk);
    wr(`MDW_CODE_ADDR, `MDW_CLEAR_CODE);
    wsig(0, 40);
    chk("short", cnt < 28, 1);
    @(posedge mclk) lph <= 1'b1;
    wr(`MDW_CODE_ADDR, `MDW_CLEAR_CODE);
    rdc("cleared", `MDW_STATUS_ADDR, 8'h6C, 8'hFF);
    wsig(0, 100);
    chk("frozen", cnt == 100, 1);
    rdc("held", `MDW_STATUS_ADDR, 8'h6C, 8'hFF);
    @(posedge mclk) lph <= 1'b0;
    wsig(0, 40);
    chk("resume", cnt < 40, 1);
    wr(`MDW_CODE_ADDR, `MDW_DISABLE_CODE);
    rdc("refused", `MDW_STATUS_ADDR, 8'h6C, 8'hFC);
    wr(`MDW_CODE_ADDR, `MDW_CLEAR_CODE);
    wr(`MDW_SETUP_ADDR, 8'h06);
    wr(`MDW_CODE_ADDR, `MDW_DISABLE_CODE);
    rdc("off", `MDW_STATUS_ADDR, 8'h0C, 8'hFF);
    wsig(0, 100);
    chk("silent", cnt == 100, 1);
    rst;
    wr(`MDW_SETUP_ADDR, 8'h0F);
    wsig(1, 40);
    chk("req", cnt < 40, 1);
    chk("req lvl", rreq, 1);
    cnt = 0;
    do begin
      cnt++;
      @(posedge mclk);
      #1;
    end while (pin_oe_n === 1'b0 && cnt < 100);
    chk("low len", 8'(cnt), 8'd25);
    test_done;
  end
  initial begin
    #200000;
    errors++;
    test_done;
  end
endmodule : mdw_watchdog_bench
`default_nettype wire
